// *** tsf_pkg.sv ***
/*
   Shared constants for the TDM serial frame front end: frame geometry,
   register map, field positions and timing figures.
   Assumes a single 250 MHz system clock; all pins are asynchronous to it.
*/
`default_nettype none
package tsf_pkg;
   localparam int          TSF_STREAMS      = 8;
   localparam int          TSF_CHAN_BITS    = 8;
   localparam int          TSF_CHANNELS     = 128;
   localparam int          TSF_FRAME_BITS   = TSF_CHANNELS * TSF_CHAN_BITS;
   localparam int          TSF_FIFO_DEPTH   = 16;

   localparam int          TSF_CLK_MHZ      = 250;
   localparam int          TSF_SCLK_KHZ     = 16384;
   localparam int          TSF_BIT_KBPS     = 8192;
   localparam int          TSF_AUX_KHZ      = 4096;
   localparam int          TSF_RST_MIN_NS   = 100;
   localparam int          TSF_RST_MIN_CYC  =
      (TSF_RST_MIN_NS * TSF_CLK_MHZ + 999) / 1000;

   localparam logic [7:0]  TSF_REG_CTRL     = 8'h00;
   localparam logic [7:0]  TSF_REG_STATUS   = 8'h04;
   localparam logic [7:0]  TSF_REG_EVAL     = 8'h08;
   localparam logic [7:0]  TSF_REG_SLIPS    = 8'h0C;

   localparam int          TSF_CTRL_OSB     = 0;
   localparam int          TSF_CTRL_RX_EN   = 1;
   localparam logic [1:0]  TSF_CTRL_RESET   = 2'h0;

   localparam int          TSF_ST_LOCKED    = 0;
   localparam int          TSF_ST_ALT_FMT   = 1;
   localparam int          TSF_ST_OVERRUN   = 2;
   localparam int          TSF_ST_WIDE      = 3;
   localparam int          TSF_ST_HIZ       = 4;

   localparam logic [9:0]  TSF_FMT_SAMPLE   = 10'h200;
   localparam logic [9:0]  TSF_LAST_BIT     = 10'h3FF;
   localparam logic [2:0]  TSF_BYTE_LAST    = 3'h7;
   localparam logic [2:0]  TSF_FETCH_BIT    = 3'h3;
endpackage : tsf_pkg
`default_nettype wire

// *** tsf_fifo.sv ***
/*
   Synchronous FIFO with valid/ready on both sides.
   Assumes one clock; width and depth are parameters, depth a power of two.
*/
`default_nettype none
module tsf_fifo #(
   parameter int WIDTH = 71,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      rd_ptr_ff;
   wire              full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                             (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   wire              empty = (wr_ptr_ff == rd_ptr_ff);
   wire              push  = in_valid && !full;
   wire              pop   = out_valid && out_ready;

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
         rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
      end
   end
endmodule : tsf_fifo
`default_nettype wire

// *** tsf_front_end.sv ***
/*
   Serial front end of a time-slot interchange: eight receive and eight
   transmit TDM streams, frame alignment with format detection, wide pulse
   mode, frame evaluation capture and a small register port.
   Assumes every pin is asynchronous to clock and the serial clock is far
   slower than clock, so each of its edges is seen after synchronising.
*/
// Overview of operation
// - Receive eight serial streams at half the serial clock rate
// - Drive eight three-state serial output streams
// - Shift data with the shared serial clock
// - Wide select picks wide or narrow alignment
// - Narrow mode detects frame sync polarity automatically
// - Wide mode aligns on negative wide pulse
// - Narrow mode uses aux input for offset measurement
// - Device reset clears counters and registers
// - Device reset floats all serial outputs
// - Frames hold 128 channels of eight bits
// - Frame sync sets channel and frame boundaries
// - Drive enable and standby both low floats outputs
`default_nettype none
module tsf_front_end #(
   parameter int STREAMS = tsf_pkg::TSF_STREAMS,
   parameter int DEPTH   = tsf_pkg::TSF_FIFO_DEPTH
) (
   input  wire logic                 clock,
   input  wire logic                 sys_rst,
   input  wire logic                 dev_reset_n,
   input  wire logic                 serial_clk_in,
   input  wire logic [STREAMS-1:0]   serial_in_lines,
   output logic      [STREAMS-1:0]   serial_out_lines,
   output logic      [STREAMS-1:0]   serial_out_oe_n,
   input  wire logic                 frame_sync_in,
   input  wire logic                 frame_eval_or_aux_clock,
   input  wire logic                 wide_pulse_select,
   input  wire logic                 output_drive_enable,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   output logic                      rx_valid,
   input  wire logic                 rx_ready,
   output logic      [6:0]           rx_chan,
   output logic      [8*STREAMS-1:0] rx_data,
   output logic                      tx_fetch,
   output logic      [6:0]           tx_chan,
   input  wire logic [8*STREAMS-1:0] tx_chan_data
);
   localparam int SW = STREAMS + 6;
   localparam int DW = 8 * STREAMS;
   localparam int FW = 7 + DW;

   // Shifts one new bit into the low end of every stream byte.
   function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] sh,
                                              input logic [STREAMS-1:0] b);
      logic [DW-1:0] r;
      r = '0;
      for (int s = 0; s < STREAMS; s++)
      begin
         r[8*s +: 8] = {sh[8*s +: 7], b[s]};
      end
      return r;
   endfunction : shift_in

   // Returns the most significant bit of every stream byte.
   function automatic logic [STREAMS-1:0] top_bits(input logic [DW-1:0] sh);
      logic [STREAMS-1:0] r;
      r = '0;
      for (int s = 0; s < STREAMS; s++)
      begin
         r[s] = sh[8*s + 7];
      end
      return r;
   endfunction : top_bits

   // Pin synchroniser: the first stage feeds only the second.
   logic [SW-1:0] pin_s1_ff;
   logic [SW-1:0] pin_s2_ff;
   wire  [SW-1:0] pin_raw = {dev_reset_n, serial_clk_in, frame_sync_in,
                             frame_eval_or_aux_clock, wide_pulse_select,
                             output_drive_enable, serial_in_lines};

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end
      else
      begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   wire [STREAMS-1:0] rx_s   = pin_s2_ff[STREAMS-1:0];
   wire               ode_s  = pin_s2_ff[STREAMS];
   wire               wide_s = pin_s2_ff[STREAMS+1];
   wire               aux_s  = pin_s2_ff[STREAMS+2];
   wire               fs_s   = pin_s2_ff[STREAMS+3];
   wire               sclk_s = pin_s2_ff[STREAMS+4];
   wire               rstn_s = pin_s2_ff[STREAMS+5];

   // Device reset pin clears the whole datapath synchronously.
   wire clr = !rstn_s;

   logic        sclk_prev_ff;
   logic        aux_prev_ff;
   logic        act_prev_ff;
   logic        wide_seen_ff;
   logic        phase_ff;
   logic [9:0]  bit_cnt_ff;
   logic        alt_fmt_ff;
   logic        locked_ff;
   logic        overrun_ff;
   logic [1:0]  ctrl_ff;
   logic [9:0]  eval_ff;
   logic [15:0] slips_ff;
   logic [DW-1:0] rx_sh_ff;
   logic [DW-1:0] tx_sh_ff;
   logic        tx_fetch_ff;
   logic [6:0]  tx_chan_ff;
   logic [STREAMS-1:0] oe_n_ff;
   logic [31:0] rdata_ff;

   wire sclk_rise = sclk_s && !sclk_prev_ff;
   wire aux_rise  = aux_s && !aux_prev_ff;

   // Narrow mode: the idle level of the sync line picks the format.
   wire narrow_act = alt_fmt_ff ? fs_s : !fs_s;
   wire narrow_start = sclk_rise && narrow_act && !act_prev_ff;
   // Wide mode: the aux clock qualifies the low-going pulse.
   wire wide_start = aux_rise && !fs_s && !wide_seen_ff;
   wire frame_start = wide_s ? wide_start : narrow_start;

   // The last bit of a frame falls on the rise that starts the next one.
   wire adv       = sclk_rise && phase_ff;
   wire byte_done = adv && (bit_cnt_ff[2:0] == tsf_pkg::TSF_BYTE_LAST);
   wire fetch_now = adv && (bit_cnt_ff[2:0] == tsf_pkg::TSF_FETCH_BIT);
   wire wrong_pos = frame_start && locked_ff &&
                    (bit_cnt_ff != tsf_pkg::TSF_LAST_BIT);

   wire [DW-1:0] nxt_rx_sh = shift_in(rx_sh_ff, rx_s);
   wire [6:0]    cur_chan  = bit_cnt_ff[9:3];

   // Receive words carry their channel number alongside the eight bytes.
   wire          fifo_in_valid = byte_done && ctrl_ff[tsf_pkg::TSF_CTRL_RX_EN]
                                 && locked_ff;
   wire          fifo_in_ready;
   wire [FW-1:0] fifo_out;
   wire          push_lost = fifo_in_valid && !fifo_in_ready;
   logic         fifo_rst_ff;

   // The FIFO is emptied by either reset; a flop keeps its reset clean.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fifo_rst_ff <= 1'b1;
      end
      else
      begin
         fifo_rst_ff <= clr;
      end
   end

   tsf_fifo #(
      .WIDTH (FW),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .sys_rst   (fifo_rst_ff),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ({cur_chan, nxt_rx_sh}),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (fifo_out)
   );

   assign rx_chan = fifo_out[FW-1:DW];
   assign rx_data = fifo_out[DW-1:0];

   // Timing state of the serial side.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_prev_ff <= 1'b0;
         aux_prev_ff  <= 1'b0;
         act_prev_ff  <= 1'b0;
         wide_seen_ff <= 1'b0;
         phase_ff     <= 1'b0;
         bit_cnt_ff   <= '0;
         alt_fmt_ff   <= 1'b0;
         locked_ff    <= 1'b0;
      end
      else if (clr)
      begin
         sclk_prev_ff <= sclk_s;
         aux_prev_ff  <= aux_s;
         act_prev_ff  <= 1'b0;
         wide_seen_ff <= 1'b0;
         phase_ff     <= 1'b0;
         bit_cnt_ff   <= '0;
         alt_fmt_ff   <= 1'b0;
         locked_ff    <= 1'b0;
      end
      else
      begin
         sclk_prev_ff <= sclk_s;
         aux_prev_ff  <= aux_s;
         if (sclk_rise)
         begin
            act_prev_ff <= narrow_act;
         end
         wide_seen_ff <= !fs_s && (wide_seen_ff || wide_start);
         if (frame_start)
         begin
            phase_ff   <= 1'b0;
            bit_cnt_ff <= '0;
            locked_ff  <= 1'b1;
         end
         else
         begin
            phase_ff <= phase_ff ^ sclk_rise;
            if (adv)
            begin
               bit_cnt_ff <= bit_cnt_ff + 10'h001;
            end
         end
         if (adv && !wide_s && (bit_cnt_ff == tsf_pkg::TSF_FMT_SAMPLE))
         begin
            alt_fmt_ff <= !fs_s;
         end
      end
   end

   // Serial shifters and the transmit fetch request.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_sh_ff    <= '0;
         tx_sh_ff    <= '0;
         tx_fetch_ff <= 1'b0;
         tx_chan_ff  <= '0;
      end
      else if (clr)
      begin
         rx_sh_ff    <= '0;
         tx_sh_ff    <= '0;
         tx_fetch_ff <= 1'b0;
         tx_chan_ff  <= '0;
      end
      else
      begin
         tx_fetch_ff <= fetch_now;
         if (fetch_now)
         begin
            tx_chan_ff <= cur_chan + 7'h01;
         end
         if (adv)
         begin
            rx_sh_ff <= nxt_rx_sh;
         end
         if (byte_done)
         begin
            tx_sh_ff <= tx_chan_data;
         end
         else if (adv)
         begin
            tx_sh_ff <= shift_in(tx_sh_ff, '0);
         end
      end
   end

   assign tx_fetch         = tx_fetch_ff;
   assign tx_chan          = tx_chan_ff;
   assign serial_out_lines = top_bits(tx_sh_ff);
   assign serial_out_oe_n  = oe_n_ff;

   wire float_out = clr ||
      (!ode_s && !ctrl_ff[tsf_pkg::TSF_CTRL_OSB]);

   // Register port: write decode, sticky status and captured figures.
   wire wr_ctrl   = reg_wr && (reg_addr == tsf_pkg::TSF_REG_CTRL);
   wire wr_status = reg_wr && (reg_addr == tsf_pkg::TSF_REG_STATUS);
   wire wr_slips  = reg_wr && (reg_addr == tsf_pkg::TSF_REG_SLIPS);
   wire ovr_clear = wr_status && reg_wdata[tsf_pkg::TSF_ST_OVERRUN];

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_ff    <= tsf_pkg::TSF_CTRL_RESET;
         overrun_ff <= 1'b0;
         eval_ff    <= '0;
         slips_ff   <= '0;
         oe_n_ff    <= '1;
      end
      else if (clr)
      begin
         ctrl_ff    <= tsf_pkg::TSF_CTRL_RESET;
         overrun_ff <= 1'b0;
         eval_ff    <= '0;
         slips_ff   <= '0;
         oe_n_ff    <= '1;
      end
      else
      begin
         oe_n_ff <= {STREAMS{float_out}};
         if (wr_ctrl)
         begin
            ctrl_ff <= reg_wdata[1:0];
         end
         overrun_ff <= push_lost || (overrun_ff && !ovr_clear);
         if (aux_rise && !wide_s)
         begin
            eval_ff <= bit_cnt_ff;
         end
         if (wrong_pos)
         begin
            slips_ff <= slips_ff + 16'h0001;
         end
         else if (wr_slips)
         begin
            slips_ff <= '0;
         end
      end
   end

   wire [31:0] status_word = {27'h0000000, float_out, wide_s, overrun_ff,
                              alt_fmt_ff, locked_ff};
   wire [31:0] read_mux =
      (reg_addr == tsf_pkg::TSF_REG_CTRL)   ? {30'h00000000, ctrl_ff} :
      (reg_addr == tsf_pkg::TSF_REG_STATUS) ? status_word :
      (reg_addr == tsf_pkg::TSF_REG_EVAL)   ? {22'h000000, eval_ff} :
      (reg_addr == tsf_pkg::TSF_REG_SLIPS)  ? {16'h0000, slips_ff} :
      32'h00000000;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= reg_rd ? read_mux : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_ff;
endmodule : tsf_front_end
`default_nettype wire

// *** tsf_fe_properties.sv ***
/* Port checks of tsf_front_end, bound into every instance.
   Assumes one clock domain with sys_rst as its reset. */
`default_nettype none
module tsf_fe_properties #(
   parameter int STREAMS = 8,
   parameter int DEPTH   = 16
) (
   input wire logic                 clock,
   input wire logic                 sys_rst,
   input wire logic                 dev_reset_n,
   input wire logic [STREAMS-1:0]   serial_out_lines,
   input wire logic [STREAMS-1:0]   serial_out_oe_n,
   input wire logic                 output_drive_enable,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   input wire logic                 rx_valid,
   input wire logic                 rx_ready,
   input wire logic [6:0]           rx_chan,
   input wire logic [8*STREAMS-1:0] rx_data,
   input wire logic                 tx_fetch
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_rst_float; !dev_reset_n [*4] |-> &serial_out_oe_n; endproperty
   a_rst_float: assert property (p_rst_float)
      else $error("outputs driven in reset");
   property p_rst_clear;
      !dev_reset_n [*4] |-> !rx_valid && !tx_fetch && serial_out_lines == '0;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("state kept in reset");
   property p_drive_on;
      (dev_reset_n && output_drive_enable) [*6] |-> serial_out_oe_n == '0;
   endproperty
   a_drive_on: assert property (p_drive_on)
      else $error("outputs not driven");
   property p_oe_same; serial_out_oe_n == '0 || &serial_out_oe_n; endproperty
   a_oe_same: assert property (p_oe_same)
      else $error("enables differ");
   property p_bit_hold;
      dev_reset_n && $changed(serial_out_lines)
         |=> $stable(serial_out_lines) [*8];
   endproperty
   a_bit_hold: assert property (p_bit_hold)
      else $error("output bit too short");
   property p_fetch_gap; tx_fetch |=> !tx_fetch [*8]; endproperty
   a_fetch_gap: assert property (p_fetch_gap)
      else $error("fetch too soon");
   property p_rx_hold;
      rx_valid && !rx_ready && dev_reset_n
         |=> rx_valid && $stable(rx_data) && $stable(rx_chan);
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("rx word changed");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("rdata without read");
   c_pop: cover property (rx_valid && rx_ready);
   c_fetch: cover property (tx_fetch);
   c_drive: cover property (serial_out_oe_n == '0);
endmodule : tsf_fe_properties
bind tsf_front_end tsf_fe_properties #(.STREAMS(STREAMS), .DEPTH(DEPTH))
   chk_u (.*);
`default_nettype wire

// *** tsf_far_side.sv ***
/* Far side model: serial clock, frame pulse, aux clock, receive data,
   capture of the transmit streams. Assumes the front end's pins. */
`default_nettype none
module tsf_far_side (
   output logic            serial_clk_in,
   output logic            frame_sync_in,
   output logic            frame_eval_or_aux_clock,
   output logic      [7:0] serial_in_lines,
   input  wire logic [7:0] serial_out_lines,
   input  wire logic [7:0] serial_out_oe_n,
   input  wire logic       wide_pulse_select,
   input  wire logic       alt
);
   timeunit 1ns;
   timeprecision 100ps;
   int          pos = 2040;
   int          q;
   logic        act;
   logic [7:0]  w = 8'h00;
   logic [7:0]  b;
   logic [63:0] sh = '0;
   logic [63:0] cap [128];

   initial
   begin
      {serial_clk_in, frame_sync_in, frame_eval_or_aux_clock} = 3'h0;
      serial_in_lines = 8'h00;
      forever
      begin
         #30.5 serial_clk_in = 1'b1;
         #30.5 serial_clk_in = 1'b0;
         if (pos % 2 == 1)
         begin
            // A floating line shows the inverse of its last level.
            w = (serial_out_lines & ~serial_out_oe_n)
               | (~w & serial_out_oe_n);
            for (int s = 0; s < 8; s++)
               sh[8*s+:8] = {sh[8*s+:7], w[s]};
            if (pos % 16 == 15)
               cap[pos / 16] = sh;
         end
         pos = (pos + 1) % 2048;
         act = wide_pulse_select ? (pos >= 2046 || pos < 2) : (pos == 0);
         frame_sync_in = (alt && !wide_pulse_select) ? act : !act;
         frame_eval_or_aux_clock = pos % 4 < 2;
         // The front end takes bit k on the rise two positions after it.
         q = (pos + 2046) % 2048;
         if (pos % 2 == 0)
            for (int s = 0; s < 8; s++)
            begin
               b = 8'(q / 16 * 3 + s * 29);
               serial_in_lines[s] = b[7 - q / 2 % 8];
            end
      end
   end
endmodule : tsf_far_side
`default_nettype wire

// *** tb_tdm_serial_frame_front_end.sv ***
/* Self-checking bench of tsf_front_end with the far side model.
   Assumes a 250 MHz clock and the model's frame timing. */
`default_nettype none
`define CHK(n, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         err_total++; \
         $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
      end \
   end
module tb_tdm_serial_frame_front_end;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock;
   logic        sys_rst;
   logic        dev_reset_n;
   logic        wide_pulse_select;
   logic        output_drive_enable;
   logic        alt;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        rx_ready;
   logic [63:0] tx_chan_data;
   wire logic   serial_clk_in;
   wire logic   frame_sync_in;
   wire logic   frame_eval_or_aux_clock;
   wire logic   [7:0] serial_in_lines;
   wire logic   [7:0] serial_out_lines;
   wire logic   [7:0] serial_out_oe_n;
   wire logic   [31:0] reg_rdata;
   wire logic   rx_valid;
   wire logic   [6:0] rx_chan;
   wire logic   [63:0] rx_data;
   wire logic   tx_fetch;
   wire logic   [6:0] tx_chan;
   int          err_total = 0;
   int          samples_checked = 0;

   tsf_front_end dut_u (.*);
   tsf_far_side far_u (.*);

   function automatic logic [63:0] word(input logic [6:0] c, input int m);
      for (int s = 0; s < 8; s++)
         word[8*s+:8] = 8'(c * m + s * (m == 3 ? 29 : 1));
   endfunction : word

   always_comb tx_chan_data = word(tx_chan, 5);

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : rd

   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      logic [31:0] d;
      for (int i = 0; i < 900; i++)
      begin
         rd(tsf_pkg::TSF_REG_STATUS, d);
         if ((d & m) === v)
            return;
         repeat (100) @(posedge clock);
      end
      `CHK("status", v, d & m)
      conclude();
   endtask : wait_st

   task automatic t_reset;
      logic [31:0] d;
      `CHK("oe_n", 8'hFF, serial_out_oe_n)
      dev_reset_n <= 1'b1;
      repeat (6) @(posedge clock);
      rd(tsf_pkg::TSF_REG_CTRL, d);
      `CHK("ctrl", 32'h0, d)
      rd(tsf_pkg::TSF_REG_STATUS, d);
      `CHK("status", 32'h10, d & 32'h1C)
      rd(tsf_pkg::TSF_REG_SLIPS, d);
      `CHK("slips", 32'h0, d)
      rd(8'h10, d);
      `CHK("unmapped", 32'h0, d)
   endtask : t_reset

   task automatic t_standby;
      wr(tsf_pkg::TSF_REG_CTRL, 32'h1);
      repeat (6) @(posedge clock);
      `CHK("oe osb", 8'h00, serial_out_oe_n)
      wr(tsf_pkg::TSF_REG_CTRL, 32'h0);
      repeat (6) @(posedge clock);
      `CHK("oe off", 8'hFF, serial_out_oe_n)
      output_drive_enable <= 1'b1;
      repeat (6) @(posedge clock);
      `CHK("oe ode", 8'h00, serial_out_oe_n)
   endtask : t_standby

   task automatic t_fifo;
      logic [31:0] d;
      logic [6:0]  c;
      wr(tsf_pkg::TSF_REG_CTRL, 32'h2);
      repeat (5000) @(posedge clock);
      rd(tsf_pkg::TSF_REG_STATUS, d);
      `CHK("overrun", 1'b1, d[tsf_pkg::TSF_ST_OVERRUN])
      for (int i = 0; i < 400 && tx_fetch !== 1'b1; i++)
         @(negedge clock);
      `CHK("tx_fetch", 1'b1, tx_fetch)
      repeat (130) @(posedge clock);
      wr(tsf_pkg::TSF_REG_CTRL, 32'h0);
      rx_ready <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge clock);
         `CHK("rx_valid", 1'b1, rx_valid)
         `CHK("rx_data", word(rx_chan, 3), rx_data)
         if (i > 0)
            `CHK("rx_chan", 7'(c + 1), rx_chan)
         c = rx_chan;
         @(posedge clock);
      end
      rx_ready <= 1'b0;
      @(negedge clock);
      `CHK("empty", 1'b0, rx_valid)
      wr(tsf_pkg::TSF_REG_STATUS, 32'h4);
      rd(tsf_pkg::TSF_REG_STATUS, d);
      `CHK("overrun clr", 1'b0, d[tsf_pkg::TSF_ST_OVERRUN])
   endtask : t_fifo

   task automatic t_tx;
      logic [6:0]  c;
      logic [31:0] d;
      rd(tsf_pkg::TSF_REG_EVAL, d);
      `CHK("eval odd", 1'b1, d[0])
      for (int k = 2; k < 6; k++)
      begin
         c = 7'(far_u.pos / 16 - k);
         `CHK("tx byte", word(c, 5), far_u.cap[c])
      end
   endtask : t_tx

   initial
   begin
      sys_rst = 1'b1;
      dev_reset_n = 1'b0;
      wide_pulse_select = 1'b0;
      output_drive_enable = 1'b0;
      alt = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rx_ready = 1'b0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (30) @(posedge clock);
      t_reset();
      t_standby();
      wait_st(32'h3, 32'h3);
      for (int i = 0; i < 40000 && far_u.pos != 16; i++)
         @(posedge clock);
      `CHK("frame pos", 16, far_u.pos)
      t_fifo();
      t_tx();
      wide_pulse_select <= 1'b1;
      wait_st(32'h9, 32'h9);
      conclude();
   end
endmodule : tb_tdm_serial_frame_front_end
`default_nettype wire
